// File: rtl/acs_seq.sv
// Purpose: Conversion sequencer of a 10-bit successive-approximation converter, APB slave.
// Assumes: One clock; the RC conversion oscillator arrives as a pin and is sampled.
// Notes:   One wait state on every APB access; unmapped addresses answer with pslverr.
// What this block does
// - Done flag sets at the end of every conversion, enable or not.
// - Flag and enable both set raise the interrupt request; in sleep it wakes.
// - Converter-on enables; writing go while enabled starts a conversion.
// - Completion clears go, sets the flag and loads both result registers.
// - Clearing go mid-conversion stops it and loads the partial value.
// - Unresolved bits of an aborted result copy the last resolved bit.
// - Reset restores registers, turns the converter off, drops conversions.
// - Result is left or right justified as the format bit selects.
// - Conversions continue in sleep only on the RC clock.
// - On the RC clock the start waits one extra instruction cycle.
// - Sleep completion with interrupt disabled powers down, on bit stays set.
// - Sleep during a system-clock conversion aborts and powers down.
// - Compare trigger sets go while the converter is on, and clears the gate timer count.
// - A full conversion lasts 11.5 conversion-clock periods.
// - Clock select picks divide 2,4,8,16,32,64 or the RC oscillator.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_seq (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        frc_clk_in,
  input  wire logic        cmp_in,
  input  wire logic        sleep_in,
  input  wire logic        trig_in,
  output logic      [9:0]  dac_code_out,
  output logic             hold_out,
  output logic             adc_power_out,
  output logic             irq_out,
  output logic             wake_out,
  output logic             gate_timer_clr_out
);
  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  // Half conversion-clock period in system clocks for each divider code.
  function automatic logic [5:0] half_period(input logic [2:0] sel);
    case (sel)
      3'h0:    half_period = 6'h01;
      3'h4:    half_period = 6'h02;
      3'h1:    half_period = 6'h04;
      3'h5:    half_period = 6'h08;
      3'h2:    half_period = 6'h10;
      default: half_period = 6'h20;
    endcase
  endfunction
  // Bits not yet resolved take the value of the last resolved bit.
  function automatic logic [9:0] fill(input logic [9:0] v, input logic [9:0] m,
                                      input logic b);
    int i;
    fill = v;
    for (i = 0; i < 10; i++) begin
      fill[i] = m[i] ? v[i] : b;
    end
  endfunction
  function automatic acs_pkg::acs_res_t justify(input logic [9:0] r, input logic left);
    justify.high = left ? r[9:2] : {6'h00, r[9:8]};
    justify.low  = left ? {r[1:0], 6'h00} : r[7:0];
  endfunction

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  acs_pkg::acs_state_t st_q;
  logic       on_q, go_q, fmt_q, flag_q, ien_q, pd_q, pready_q, pslverr_q;
  logic [2:0] sel_q;
  logic [9:0] res_q, sar_q, oh_q, rmask_q;
  logic       last_q, hold_q, irq_q, wake_q, gclr_q;
  logic [4:0] hc_q, wcnt_q;
  logic [5:0] div_q;
  logic [31:0] prdata_q;
  logic       frc_s1_q, frc_s2_q, frc_s3_q, pwr_q;

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  // A single wait state lets read data come from a flop.
  wire        acc    = psel_in & penable_in & pready_q;
  wire        wr     = acc & pwrite_in;
  wire        hit_a  = paddr_in == `ACS_OFF_CTRL_A;
  wire        hit_b  = paddr_in == `ACS_OFF_CTRL_B;
  wire        hit_h  = paddr_in == `ACS_OFF_RES_HI;
  wire        hit_l  = paddr_in == `ACS_OFF_RES_LO;
  wire        hit_f  = paddr_in == `ACS_OFF_FLAG;
  wire        hit_e  = paddr_in == `ACS_OFF_IRQ_EN;
  wire        mapped = hit_a | hit_b | hit_h | hit_l | hit_f | hit_e;
  wire        wr_a   = wr & hit_a;
  wire        wr_go  = wr_a & pwdata_in[`ACS_BIT_GO];
  wire        wr_stop = wr_a & ~pwdata_in[`ACS_BIT_GO];
  wire        wr_off = wr_a & ~pwdata_in[`ACS_BIT_ON];
  wire acs_pkg::acs_res_t res_j = justify(res_q, fmt_q);
  wire [31:0] rd_w = hit_a ? {30'h0, go_q, on_q} :
                     hit_b ? {24'h0, fmt_q, sel_q, 4'h0} :
                     hit_h ? {24'h0, res_j.high} :
                     hit_l ? {24'h0, res_j.low} :
                     hit_f ? {31'h0, flag_q} :
                     hit_e ? {31'h0, ien_q} : 32'h0;

  // -----------------------------------------------------------------
  // Conversion timing
  // -----------------------------------------------------------------
  // RC edges are taken only from the second synchroniser stage.
  wire rc_sel   = sel_q[1:0] == 2'b11;
  wire rc_edge  = frc_s2_q ^ frc_s3_q;
  wire div_tick = div_q == half_period(sel_q) - 6'h01;
  wire tick     = rc_sel ? rc_edge : div_tick;
  wire [4:0] hc_n = hc_q + 5'h01;
  wire resolve  = tick & hc_n[0] & hc_n >= `ACS_HALF_FIRST & hc_n <= `ACS_HALF_BITEND;
  wire finish   = (st_q == acs_pkg::ACS_CONV) & tick & hc_n == `ACS_HALF_LAST;
  wire sl_abort = sleep_in & ~rc_sel & st_q != acs_pkg::ACS_IDLE;
  wire sw_abort = (st_q == acs_pkg::ACS_CONV) & ~go_q & ~sl_abort;
  wire start    = (st_q == acs_pkg::ACS_IDLE) & go_q & on_q & ~pd_q;
  wire [9:0] part = fill(sar_q, rmask_q, last_q);
  // The comparator follows the trial code that this block drives, so it is read directly.
  // Two sync stages would hand over the previous bit's decision at the two-cycle bit period.
  wire [9:0] sar_n = (sar_q & ~oh_q) | (cmp_in ? oh_q : 10'h000) | (oh_q >> 1);
  wire trig_go  = trig_in & on_q;
  wire flag_set = finish & ~sl_abort;
  wire done_pd  = flag_set & sleep_in & ~ien_q;
  wire pd_nx    = sl_abort | done_pd | (pd_q & sleep_in);
  wire on_nx    = wr_a ? pwdata_in[`ACS_BIT_ON] : on_q;
  wire flag_d   = flag_set | (flag_q & ~(wr & hit_f & ~pwdata_in[`ACS_BIT_DONE]));
  wire irq_d    = flag_q & ien_q;

  // -----------------------------------------------------------------
  // Synchroniser for the RC clock pin
  // -----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    frc_s1_q <= frc_clk_in;
    frc_s2_q <= frc_s1_q;
    frc_s3_q <= frc_s2_q;
  end

  // -----------------------------------------------------------------
  // Bus slave
  // -----------------------------------------------------------------
  // Ready rises one cycle into the access phase and drops after it.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel_in & penable_in & ~pready_q;
      pslverr_q <= psel_in & penable_in & ~pready_q & ~mapped;
      prdata_q  <= (psel_in & penable_in & ~pready_q & ~pwrite_in) ? rd_w : 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------
  // Software registers
  // -----------------------------------------------------------------
  // Go is taken only when the converter was already on before the write.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      on_q   <= `ACS_RST_BIT;
      go_q   <= `ACS_RST_BIT;
      fmt_q  <= `ACS_RST_BIT;
      sel_q  <= `ACS_RST_SEL;
      ien_q  <= `ACS_RST_BIT;
      flag_q <= `ACS_RST_BIT;
    end else begin
      if (wr_a) begin
        on_q <= pwdata_in[`ACS_BIT_ON];
      end
      if (wr & hit_b) begin
        fmt_q <= pwdata_in[`ACS_BIT_FMT];
        sel_q <= pwdata_in[`ACS_SEL_LSB +: 3];
      end
      if (wr & hit_e) begin
        ien_q <= pwdata_in[`ACS_BIT_IEN];
      end
      // A completion in the same cycle as a software clear keeps the flag set.
      flag_q <= flag_d;
      // Trigger wins over a software stop in the same cycle.
      if (trig_go) begin
        go_q <= 1'b1;
      end else if (finish | sl_abort | wr_off | wr_stop) begin
        go_q <= 1'b0;
      end else if (wr_go & on_q) begin
        go_q <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  // The divider restarts at each start so the first half period is whole.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_q    <= acs_pkg::ACS_IDLE;
      div_q   <= 6'h00;
      hc_q    <= 5'h00;
      wcnt_q  <= 5'h00;
      sar_q   <= `ACS_RST_RES;
      oh_q    <= `ACS_SAR_INIT;
      rmask_q <= `ACS_RST_RES;
      last_q  <= 1'b0;
      res_q   <= `ACS_RST_RES;
      pd_q    <= 1'b0;
      hold_q  <= 1'b0;
    end else begin
      div_q <= (div_tick | st_q != acs_pkg::ACS_CONV) ? 6'h00 : div_q + 6'h01;
      if (sl_abort | done_pd) begin
        pd_q <= 1'b1;
      end else if (~sleep_in) begin
        pd_q <= 1'b0;
      end
      case (st_q)
        acs_pkg::ACS_IDLE: begin
          hc_q    <= 5'h00;
          wcnt_q  <= 5'h00;
          sar_q   <= `ACS_SAR_INIT;
          oh_q    <= `ACS_SAR_INIT;
          rmask_q <= `ACS_RST_RES;
          last_q  <= 1'b0;
          if (start) begin
            st_q <= rc_sel ? acs_pkg::ACS_WAIT : acs_pkg::ACS_CONV;
          end
        end
        acs_pkg::ACS_WAIT: begin
          wcnt_q <= wcnt_q + 5'h01;
          if (sl_abort | ~go_q) begin
            st_q <= acs_pkg::ACS_IDLE;
          end else if (wcnt_q == 5'(`ACS_TCY_CYC - 1)) begin
            st_q <= acs_pkg::ACS_CONV;
          end
        end
        acs_pkg::ACS_CONV: begin
          if (sl_abort) begin
            st_q <= acs_pkg::ACS_IDLE;
          end else if (sw_abort) begin
            res_q <= part;
            st_q  <= acs_pkg::ACS_IDLE;
          end else if (finish) begin
            res_q <= sar_q;
            st_q  <= acs_pkg::ACS_IDLE;
          end else if (tick) begin
            hc_q <= hc_n;
            if (resolve) begin
              sar_q   <= sar_n;
              rmask_q <= rmask_q | oh_q;
              oh_q    <= oh_q >> 1;
              last_q  <= cmp_in;
            end
          end
        end
        default: st_q <= acs_pkg::ACS_IDLE;
      endcase
      hold_q <= st_q == acs_pkg::ACS_CONV & ~(finish | sw_abort | sl_abort);
    end
  end

  // -----------------------------------------------------------------
  // Event outputs
  // -----------------------------------------------------------------
  // The request follows flag and enable in sleep too, and wakes the core.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
      gclr_q <= 1'b0;
      pwr_q  <= 1'b0;
    end else begin
      irq_q  <= irq_d;
      wake_q <= irq_d & sleep_in;
      gclr_q <= trig_in;
      // Power follows the next on and power-down values so it lags neither.
      pwr_q  <= on_nx & ~pd_nx;
    end
  end

  assign prdata_out         = prdata_q;
  assign pready_out         = pready_q;
  assign pslverr_out        = pslverr_q;
  assign dac_code_out       = sar_q;
  assign hold_out           = hold_q;
  assign adc_power_out      = pwr_q;
  assign irq_out            = irq_q;
  assign wake_out           = wake_q;
  assign gate_timer_clr_out = gclr_q;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  done_sets_flag_a: assert property (finish && !sl_abort |=> flag_q && !go_q
    && res_q == $past(sar_q)) else $error("completion did not set flag and load result");
  irq_req_a: assert property (flag_q && ien_q |=> irq_out)
    else $error("interrupt request missing");
  wake_req_a: assert property (flag_q && ien_q && sleep_in |=> wake_out)
    else $error("wake request missing");
  start_conv_a: assert property (start && !rc_sel && !sl_abort |=> st_q == acs_pkg::ACS_CONV)
    else $error("conversion did not start");
  abort_fill_a: assert property (sw_abort |=> res_q == $past(part)
    && st_q == acs_pkg::ACS_IDLE) else $error("aborted result wrong");
  reset_off_a: assert property (disable iff (1'b0) sys_rst_in |=> !on_q
    && !go_q && st_q == acs_pkg::ACS_IDLE) else $error("reset did not clear converter");
  rc_delay_a: assert property (start && rc_sel && !sleep_in && go_q ##1 go_q
    |-> (st_q == acs_pkg::ACS_WAIT)) else $error("RC start not delayed");
  sleep_abort_a: assert property (sl_abort |=> st_q == acs_pkg::ACS_IDLE
    && pd_q && !adc_power_out) else $error("sleep abort failed");
  sleep_pd_a: assert property (done_pd |=> pd_q)
    else $error("sleep completion did not power down");
  trig_go_a: assert property (trig_in && on_q |=> go_q && gate_timer_clr_out)
    else $error("trigger did not set go");
  conv_len_a: assert property (start && !rc_sel && sel_q == 3'h0 && !sleep_in ##1
    (go_q && !sleep_in)[*8] |-> st_q == acs_pkg::ACS_CONV) else $error("conversion too short");
endmodule

// File: rtl/acs_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes: A 32-bit register bus; each register takes one aligned word.
// Notes:   Definitions only.
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define ACS_OFF_CTRL_A  8'h00
`define ACS_OFF_CTRL_B  8'h04
`define ACS_OFF_RES_HI  8'h08
`define ACS_OFF_RES_LO  8'h0C
`define ACS_OFF_FLAG    8'h10
`define ACS_OFF_IRQ_EN  8'h14
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define ACS_BIT_ON      0
`define ACS_BIT_GO      1
`define ACS_BIT_FMT     7
`define ACS_SEL_LSB     4
`define ACS_BIT_DONE    0
`define ACS_BIT_IEN     0
// -----------------------------------------------------------------
// Reset values and conversion constants
// -----------------------------------------------------------------
`define ACS_RST_BIT     1'b0
`define ACS_RST_SEL     3'h0
`define ACS_RST_RES     10'h000
`define ACS_SAR_INIT    10'h200
`define ACS_HALF_LAST   5'd23
`define ACS_HALF_FIRST  5'd3
`define ACS_HALF_BITEND 5'd21
`define ACS_CLK_NS      8
`define ACS_TCY_NS      125
`define ACS_TCY_CYC     ((`ACS_TCY_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`endif

// File: rtl/acs_pkg.sv
// Purpose: Types shared by the conversion sequencer.
// Assumes: Constants live in acs_consts.svh.
// Notes:   Types only.
package acs_pkg;
  typedef enum logic [1:0] {ACS_IDLE, ACS_WAIT, ACS_CONV} acs_state_t;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } acs_res_t;
endpackage

// File: verif/acs_analog_model.sv
// Purpose: Stand-in for the sample-and-hold, comparator and RC oscillator.
// Assumes: The bench sets the held input as a 10-bit code.
// Notes:   Behavioural only; the comparator answers at once.
`timescale 1ns/1ps
module acs_analog_model (
  input  wire logic       hold_in,
  input  wire logic [9:0] dac_code_in,
  input  wire logic [9:0] level_in,
  output logic            cmp_out,
  output logic            frc_clk_out
);
  // The RC oscillator runs free, its phase unrelated to the system clock.
  initial frc_clk_out = 1'b0;
  always #403 frc_clk_out = ~frc_clk_out;

  // Compare only while held; otherwise flip, so a stale decision is never usable.
  initial cmp_out = 1'b0;
  always @(dac_code_in or hold_in or level_in) begin
    if (hold_in) cmp_out = (level_in >= dac_code_in);
    else cmp_out = ~cmp_out;
  end
endmodule

// File: verif/adc_conversion_sequencer_test.sv
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: One wait state per APB access; analog side from acs_analog_model.
// Notes:   Each scenario is a task of its own and judges its own results.
`timescale 1ns/1ps
`include "acs_consts.svh"
module adc_conversion_sequencer_test;
  // ---------------------------------------------------------------
  // Signals and counters
  // ---------------------------------------------------------------
  logic        mclk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        sleep = 1'b0;
  logic        trig = 1'b0;
  logic [9:0]  level = 10'h000;
  logic [31:0] prdata, rd;
  logic [9:0]  dac_code;
  logic        pready, pslverr, err, frc_clk, cmp, hold, power, irq, wake, tclr;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          hcnt = 0;

  acs_seq uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .frc_clk_in(frc_clk), .cmp_in(cmp), .sleep_in(sleep), .trig_in(trig),
    .dac_code_out(dac_code), .hold_out(hold), .adc_power_out(power), .irq_out(irq),
    .wake_out(wake), .gate_timer_clr_out(tclr));
  acs_analog_model model (.hold_in(hold), .dac_code_in(dac_code), .level_in(level),
    .cmp_out(cmp), .frc_clk_out(frc_clk));

  // Clock of 8 ns period.
  always #4 mclk_in = ~mclk_in;

  // Counts held cycles and cuts a hang short far above the longest expected run.
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (hold === 1'b1) hcnt <= hcnt + 1;
    if (cyc == 40000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("TB: %0d mismatches in %0d checks", fail_count, total_checks);
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t saw %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_in);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // Polls the go bit as software would; bounded so a stuck bit cannot hang.
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, `ACS_OFF_CTRL_A, 32'h0000_0000);
      n++;
    end while (rd[`ACS_BIT_GO] !== 1'b0 && n < 400);
    check({31'h0, rd[`ACS_BIT_GO]}, 32'h0000_0000);
  endtask

  task automatic start(input logic [2:0] sel, input logic fmt, input logic [9:0] v);
    level = v;
    apb(1'b1, `ACS_OFF_CTRL_B, {24'h00_0000, fmt, sel, 4'h0});
    apb(1'b1, `ACS_OFF_CTRL_A, 32'h0000_0001);
    hcnt = 0;
    apb(1'b1, `ACS_OFF_CTRL_A, 32'h0000_0003);
  endtask

  task automatic res_check(input logic fmt, input logic [9:0] v);
    rdc(`ACS_OFF_RES_HI, fmt ? {24'h00_0000, v[9:2]} : {30'h0000_0000, v[9:8]});
    rdc(`ACS_OFF_RES_LO, fmt ? {24'h00_0000, v[1:0], 6'h00} : {24'h00_0000, v[7:0]});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // All registers read zero; an unmapped word answers with an error.
  task automatic t_reset_values();
    for (int a = 0; a < 24; a += 4) rdc(8'(a), 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
  endtask

  // Every system-derived clock select, alternating format, with duration check.
  task automatic t_clock_table();
    logic [2:0] sels [6];
    logic [9:0] v;
    sels = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110};
    for (int i = 0; i < 6; i++) begin
      v = 10'h2A5 + 10'(i * 83);
      start(sels[i], i[0], v);
      wait_done();
      check({31'h0, hcnt >= 23 * (1 << i) - 1 && hcnt <= 23 * (1 << i) + 1}, 32'h0000_0001);
      res_check(i[0], v);
      rdc(`ACS_OFF_FLAG, 32'h0000_0001);
      check({31'h0, irq}, 32'h0000_0000);
      apb(1'b1, `ACS_OFF_FLAG, 32'h0000_0000);
    end
  endtask

  // Flag with enable raises the request; writing one never clears the flag.
  task automatic t_irq();
    apb(1'b1, `ACS_OFF_IRQ_EN, 32'h0000_0001);
    start(3'b000, 1'b0, 10'h155);
    wait_done();
    check({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, `ACS_OFF_FLAG, 32'h0000_0001);
    rdc(`ACS_OFF_FLAG, 32'h0000_0001);
    apb(1'b1, `ACS_OFF_FLAG, 32'h0000_0000);
    repeat (2) @(posedge mclk_in);
    check({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `ACS_OFF_IRQ_EN, 32'h0000_0000);
  endtask

  // Stop mid-way on an all-ones input: zero-filled tails would show.
  task automatic t_abort();
    start(3'b110, 1'b0, 10'h3FF);
    repeat (300) @(posedge mclk_in);
    apb(1'b1, `ACS_OFF_CTRL_A, 32'h0000_0001);
    res_check(1'b0, 10'h3FF);
    check({31'h0, hold}, 32'h0000_0000);
  endtask

  // Sleep on a system-derived clock abandons the conversion, on bit stays set.
  task automatic t_sleep_sys();
    apb(1'b1, `ACS_OFF_FLAG, 32'h0000_0000);
    start(3'b110, 1'b0, 10'h0F0);
    repeat (50) @(posedge mclk_in);
    sleep <= 1'b1;
    repeat (4) @(posedge mclk_in);
    check({30'h0, hold, power}, 32'h0000_0000);
    apb(1'b0, `ACS_OFF_CTRL_A, 32'h0000_0000);
    check({31'h0, rd[`ACS_BIT_ON]}, 32'h0000_0001);
    rdc(`ACS_OFF_FLAG, 32'h0000_0000);
    sleep <= 1'b0;
    repeat (3) @(posedge mclk_in);
    check({31'h0, power}, 32'h0000_0001);
  endtask

  // Compare trigger sets go and pulses the gate timer clear.
  task automatic t_trigger();
    apb(1'b1, `ACS_OFF_CTRL_B, 32'h0000_0000);
    trig <= 1'b1;
    @(posedge mclk_in);
    trig <= 1'b0;
    @(posedge mclk_in);
    check({31'h0, tclr}, 32'h0000_0001);
    rdc(`ACS_OFF_CTRL_A, 32'h0000_0003);
    wait_done();
    rdc(`ACS_OFF_FLAG, 32'h0000_0001);
    apb(1'b1, `ACS_OFF_FLAG, 32'h0000_0000);
  endtask

  // Reset in mid-conversion drops it and restores every register.
  task automatic t_reset_mid();
    start(3'b110, 1'b1, 10'h111);
    repeat (40) @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    check({30'h0, hold, power}, 32'h0000_0000);
    t_reset_values();
  endtask

  // RC clock converts through sleep after a delayed start; the enable decides wake.
  task automatic t_sleep_rc(input logic ien);
    int n;
    n = 0;
    apb(1'b1, `ACS_OFF_IRQ_EN, {31'h0, ien});
    start(3'b011, 1'b1, 10'h2C3);
    sleep <= 1'b1;
    repeat (11) @(posedge mclk_in);
    check({31'h0, hold}, 32'h0000_0000);
    do begin
      @(posedge mclk_in);
      n++;
    end while ((hcnt == 0 || hold === 1'b1) && n < 3000);
    repeat (3) @(posedge mclk_in);
    check({30'h0, wake, power}, {30'h0, ien, ien});
    sleep <= 1'b0;
    apb(1'b0, `ACS_OFF_CTRL_A, 32'h0000_0000);
    check({31'h0, rd[`ACS_BIT_ON]}, 32'h0000_0001);
    rdc(`ACS_OFF_FLAG, 32'h0000_0001);
    res_check(1'b1, 10'h2C3);
    apb(1'b1, `ACS_OFF_FLAG, 32'h0000_0000);
  endtask

  // Main sequence: reset held three cycles, then every scenario in turn.
  initial begin
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    t_reset_values();
    t_clock_table();
    t_irq();
    t_abort();
    t_sleep_sys();
    t_trigger();
    t_reset_mid();
    t_sleep_rc(1'b1);
    t_sleep_rc(1'b0);
    print_verdict();
  end
endmodule
